/* design/dta_core.sv */
`include "dta_consts.svh"
`default_nettype none

module dta_core #(
  parameter int CPUS      = `DTA_CPU_COUNT,
  parameter int PRESC_DIV = `DTA_PRESC_DIV
) (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire dta_pkg::dta_bus_type bus_req,
  output var  logic [7:0]           bus_rdata,
  output var  logic [CPUS-1:0]      irq,
  input  wire logic                 event_pin_in,
  output var  logic                 event_pin_out,
  output var  logic                 event_pin_oe
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (CPUS != `DTA_CPU_COUNT) begin : g_bad_cpus
    $error("dta_core: one cpu select bit serves exactly two cpus");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [`DTA_COUNT_W-1:0] count;
  logic [7:0]              reload_low_byte;
  logic [7:0]              reload_high_byte;
  logic [7:0]              upper_snapshot;
  logic                    underflow_flag;
  logic                    running;
  logic                    presc_sel;
  logic [CPUS-1:0]         int_enable;
  dta_pkg::dta_mode_type   mode_field;
  logic                    pin_s1;
  logic                    pin_s2;
  logic                    pin_s3;
  logic                    pin_level;
  logic                    pin_fall;
  logic                    presc_tick;

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  dta_prescaler #(
    .DIV   (PRESC_DIV)
  ) u_prescaler (
    .clock (clock),
    .rst_n (rst_n),
    .tick  (presc_tick)
  );

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire logic rd      = bus_req.sel & bus_req.rw;
  wire logic wr      = bus_req.sel & ~bus_req.rw;
  wire logic at_csr  = bus_req.addr == `DTA_ADDR_CONTROL;
  wire logic at_low  = bus_req.addr == `DTA_ADDR_COUNT_LOW;
  wire logic at_snap = bus_req.addr == `DTA_ADDR_SNAPSHOT;
  wire logic at_high = bus_req.addr == `DTA_ADDR_SHARED_HIGH;

  // Direction picks the register at shared addresses
  wire logic rd_low   = rd & at_low;
  wire logic rd_clear = rd & at_high;
  wire logic wr_low   = wr & at_snap;
  wire logic wr_high  = wr & at_high;
  wire logic wr_csr   = wr & at_csr;

  // ----------------------------------------
  // Count enable selection
  // ----------------------------------------
  wire logic mode_on   = mode_field != dta_pkg::DTA_MODE_OFF;
  wire logic presc_ok  = ~presc_sel | presc_tick;
  wire logic is_event  = mode_field == dta_pkg::DTA_MODE_EVENT;
  wire logic is_width  = mode_field == dta_pkg::DTA_MODE_WIDTH;
  wire logic is_retrig = mode_field == dta_pkg::DTA_MODE_RETRIG;
  wire logic is_p_one  = mode_field == dta_pkg::DTA_MODE_PULSE_ONE;
  wire logic is_p_free = mode_field == dta_pkg::DTA_MODE_PULSE_FREE;
  wire logic one_shot  = is_retrig | is_p_one
                       | (mode_field == dta_pkg::DTA_MODE_ONE_SHOT);

  // System clock, event edge or prescaled rate
  wire logic step = ~mode_on  ? 1'b0 :
                    is_event  ? running & pin_fall :
                    is_width  ? running & ~pin_level :
                                running & presc_ok;

  wire logic at_zero = count == `DTA_COUNT_RST;
  wire logic wrap    = step & at_zero;

  // Upper latch write starts every mode except off and retrigger
  wire logic start   = wr_high & mode_on & ~is_retrig;
  wire logic retrig  = is_retrig & pin_fall;
  wire logic loading = wr_high | retrig;

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  wire logic [`DTA_COUNT_W-1:0] latch_word = {reload_high_byte,
                                              reload_low_byte};

  wire logic [`DTA_COUNT_W-1:0] next_count =
    wr_high ? {bus_req.wdata, reload_low_byte} :
    retrig  ? latch_word :
    wrap    ? latch_word :
    step    ? count - `DTA_COUNT_ONE :
              count;

  wire logic next_running =
    wr_csr             ? 1'b0 :
    (start | retrig)   ? 1'b1 :
    (wrap & one_shot)  ? 1'b0 :
                         running;

  // Set wins over a clear in the same cycle
  wire logic next_underflow_flag =
    wrap | (underflow_flag & ~(rd_clear | wr_high));

  wire logic next_pin_out =
    wr_csr                         ? 1'b1 :
    (start & (is_p_one | is_p_free)) ? 1'b0 :
    (wrap & is_p_one)              ? 1'b1 :
    (wrap & is_p_free)             ? ~event_pin_out :
                                     event_pin_out;

  // Control/status read view for the accessing cpu
  wire logic [7:0] csr_view = {
    underflow_flag,
    pin_level,
    1'b0,
    int_enable[bus_req.cpu],
    presc_sel,
    mode_field
  };

  wire logic [7:0] next_rdata =
    at_csr              ? csr_view :
    at_low              ? count[7:0] :
    (at_snap | at_high) ? upper_snapshot :
                          `DTA_BYTE_ZERO;

  // ----------------------------------------
  // Event pin synchroniser and edge
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1    <= 1'b0;
      pin_s2    <= 1'b0;
      pin_s3    <= 1'b0;
      pin_level <= 1'b0;
      pin_fall  <= 1'b0;
    end else begin
      pin_s1    <= event_pin_in;
      pin_s2    <= pin_s1;
      pin_s3    <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_level <= pin_s3;
      end
      pin_fall  <= pin_level & (pin_s2 == pin_s3) & ~pin_s3;
    end
  end

  // ----------------------------------------
  // Counter, latches and flag
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count            <= `DTA_COUNT_RST;
      reload_low_byte  <= `DTA_BYTE_ZERO;
      reload_high_byte <= `DTA_BYTE_ZERO;
      upper_snapshot   <= `DTA_BYTE_ZERO;
      underflow_flag   <= 1'b0;
      running          <= 1'b0;
    end else begin
      count          <= next_count;
      running        <= next_running;
      underflow_flag <= next_underflow_flag;
      if (wr_low) begin
        reload_low_byte <= bus_req.wdata;
      end
      if (wr_high) begin
        reload_high_byte <= bus_req.wdata;
      end
      if (rd_low) begin
        upper_snapshot <= count[15:8];
      end
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_field <= dta_pkg::DTA_MODE_OFF;
      presc_sel  <= 1'b0;
    end else if (wr_csr) begin
      mode_field <= dta_pkg::dta_mode_type'(
        bus_req.wdata[`DTA_CSR_MODE_MSB:`DTA_CSR_MODE_LSB]);
      presc_sel  <= bus_req.wdata[`DTA_CSR_PRESC_BIT];
    end
  end

  // ----------------------------------------
  // Per-cpu enable and interrupt request
  // ----------------------------------------
  for (genvar i = 0; i < CPUS; i++) begin : g_cpu
    wire logic own_wr = wr_csr & (bus_req.cpu == 1'(i));
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        int_enable[i] <= 1'b0;
        irq[i]        <= 1'b0;
      end else begin
        if (own_wr) begin
          int_enable[i] <= bus_req.wdata[`DTA_CSR_IE_BIT];
        end
        irq[i] <= underflow_flag & int_enable[i];
      end
    end
  end

  // ----------------------------------------
  // Read data and pulse output
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata     <= `DTA_BYTE_ZERO;
      event_pin_out <= 1'b1;
      event_pin_oe  <= 1'b0;
    end else begin
      if (rd) begin
        bus_rdata <= next_rdata;
      end
      event_pin_out <= next_pin_out;
      event_pin_oe  <= is_p_one | is_p_free;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_reload;
    @(posedge clock) disable iff (!rst_n)
    wrap && !loading |=> count == $past(latch_word);
  endproperty
  a_reload: assert property (p_reload)
    else $error("latch not reloaded at zero step");

  property p_decrement;
    @(posedge clock) disable iff (!rst_n)
    step && !at_zero && !loading
      |=> count == $past(count) - `DTA_COUNT_ONE;
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("count did not step down by one");

  property p_flag_set;
    @(posedge clock) disable iff (!rst_n)
    wrap |=> underflow_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("underflow flag missed at zero step");

  property p_flag_view;
    @(posedge clock) disable iff (!rst_n)
    rd && at_csr
      |=> bus_rdata[`DTA_CSR_FLAG_BIT] == $past(underflow_flag);
  endproperty
  a_flag_view: assert property (p_flag_view)
    else $error("flag bit does not show underflow flag");

  property p_snapshot;
    @(posedge clock) disable iff (!rst_n)
    rd_low |=> upper_snapshot == $past(count[15:8]);
  endproperty
  a_snapshot: assert property (p_snapshot)
    else $error("snapshot not taken on low byte read");

  property p_flag_clear;
    @(posedge clock) disable iff (!rst_n)
    (rd_clear || wr_high) && !wrap |=> !underflow_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag not cleared at shared address");

  property p_irq;
    @(posedge clock) disable iff (!rst_n)
    underflow_flag && int_enable[0] |=> irq[0];
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised for enabled cpu");

  property p_level;
    @(posedge clock) disable iff (!rst_n)
    rd && at_csr |=> bus_rdata[`DTA_CSR_LEVEL_BIT] == $past(pin_level);
  endproperty
  a_level: assert property (p_level)
    else $error("level bit does not follow event pin");

  property p_stopped;
    @(posedge clock) disable iff (!rst_n)
    !mode_on && !loading |=> $stable(count);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("count moved while timer off");

  property p_start;
    @(posedge clock) disable iff (!rst_n)
    start |=> count == {$past(bus_req.wdata), reload_low_byte} && running;
  endproperty
  a_start: assert property (p_start)
    else $error("upper latch write did not load and start");

  property p_prescaled;
    @(posedge clock) disable iff (!rst_n)
    step && presc_sel && !is_event && !is_width |-> presc_tick;
  endproperty
  a_prescaled: assert property (p_prescaled)
    else $error("count stepped without prescaler pulse");

endmodule // dta_core

`default_nettype wire

/* include/dta_consts.svh */
`ifndef DTA_CONSTS_SVH
`define DTA_CONSTS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define DTA_ADDR_CONTROL     8'h16
`define DTA_ADDR_COUNT_LOW   8'h17
`define DTA_ADDR_SNAPSHOT    8'h18
`define DTA_ADDR_SHARED_HIGH 8'h19

// ----------------------------------------
// Control/status field positions
// ----------------------------------------
`define DTA_CSR_FLAG_BIT  7
`define DTA_CSR_LEVEL_BIT 6
`define DTA_CSR_IE_BIT    4
`define DTA_CSR_PRESC_BIT 3
`define DTA_CSR_MODE_MSB  2
`define DTA_CSR_MODE_LSB  0

// ----------------------------------------
// Widths, reset values and counts
// ----------------------------------------
`define DTA_COUNT_W     16
`define DTA_BYTE_ZERO   8'h00
`define DTA_COUNT_RST   16'h0000
`define DTA_COUNT_ONE   16'h0001
`define DTA_PRESC_DIV   128
`define DTA_CPU_COUNT   2

`endif

/* include/dta_pkg.sv */
`default_nettype none

package dta_pkg;

  // Mode codes of the control/status mode field
  typedef enum logic [2:0] {
    DTA_MODE_OFF        = 3'h0,
    DTA_MODE_EVENT      = 3'h1,
    DTA_MODE_WIDTH      = 3'h2,
    DTA_MODE_RETRIG     = 3'h3,
    DTA_MODE_ONE_SHOT   = 3'h4,
    DTA_MODE_FREE_RUN   = 3'h5,
    DTA_MODE_PULSE_ONE  = 3'h6,
    DTA_MODE_PULSE_FREE = 3'h7
  } dta_mode_type;

  // One processor bus access, valid for the cycle sel is high
  typedef struct packed {
    logic       sel;
    logic       rw;
    logic       cpu;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dta_bus_type;

endpackage

`default_nettype wire

/* design/dta_prescaler.sv */
`include "dta_consts.svh"
`default_nettype none

module dta_prescaler #(
  parameter int DIV = `DTA_PRESC_DIV
) (
  input  wire logic clock,
  input  wire logic rst_n,
  output var  logic tick
);

  localparam int W = $clog2(DIV);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (DIV < 2) begin : g_bad_div
    $error("dta_prescaler: DIV must be at least 2");
  end

  logic [W-1:0] div_count;
  wire  logic   div_last = (div_count == W'(DIV - 1));

  // Free-running divider, one pulse per DIV cycles
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_count <= '0;
      tick      <= 1'b0;
    end else begin
      div_count <= div_last ? '0 : W'(div_count + 1'b1);
      tick      <= div_last;
    end
  end

endmodule // dta_prescaler

`default_nettype wire

/* dv/dta_core_bench.sv */
`include "dta_consts.svh"
`default_nettype none

module dta_core_bench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int DIV = 4;

  logic                 clock;
  logic                 rst_n;
  dta_pkg::dta_bus_type bus_req;
  logic [7:0]           bus_rdata;
  logic [1:0]           irq;
  logic                 event_pin_in;
  logic                 event_pin_out;
  logic                 event_pin_oe;
  int                   errors;
  int                   checks_done;
  logic [7:0]           d;
  logic [7:0]           e;

  dta_core #(
    .CPUS      (2),
    .PRESC_DIV (DIV)
  ) dut (
    .clock         (clock),
    .rst_n         (rst_n),
    .bus_req       (bus_req),
    .bus_rdata     (bus_rdata),
    .irq           (irq),
    .event_pin_in  (event_pin_in),
    .event_pin_out (event_pin_out),
    .event_pin_oe  (event_pin_oe)
  );

  // ----------------------------------------
  // Clock
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One write cycle, strobe held across one rising edge
  task automatic wr(input logic cpu, input logic [7:0] a,
                    input logic [7:0] v);
    @(negedge clock);
    bus_req = '{sel: 1'b1, rw: 1'b0, cpu: cpu, addr: a, wdata: v};
    @(negedge clock);
    bus_req.sel = 1'b0;
  endtask

  // One read cycle, data taken once the answering edge has passed
  task automatic rd(input logic cpu, input logic [7:0] a,
                    output logic [7:0] v);
    @(negedge clock);
    bus_req = '{sel: 1'b1, rw: 1'b1, cpu: cpu, addr: a, wdata: 8'h00};
    @(negedge clock);
    bus_req.sel = 1'b0;
    v = bus_rdata;
  endtask

  // Event pin moved, then held long enough to pass the synchroniser
  task automatic pin_to(input logic v);
    @(negedge clock);
    event_pin_in = v;
    repeat (6) @(negedge clock);
  endtask

  // Bounded wait for the first processor's interrupt
  task automatic wait_irq(input int limit);
    int n;
    n = 0;
    while (irq[0] !== 1'b1 && n < limit) begin
      @(negedge clock);
      n++;
    end
    if (n >= limit) begin
      errors++;
      $display("FAIL %0t: interrupt never came", $time);
      results();
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    errors = 0;
    checks_done = 0;
    rst_n = 1'b0;
    bus_req = '0;
    event_pin_in = 1'b1;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    // Let the idle pin level pass the synchroniser
    repeat (5) @(negedge clock);

    // Reset state and pin level mirror
    rd(1'b0, `DTA_ADDR_CONTROL, d);
    check(d, 8'h40, "control after reset");
    check({6'h00, irq}, 8'h00, "irq after reset");
    check({7'h00, event_pin_oe}, 8'h00, "pin enable after reset");
    pin_to(1'b0);
    rd(1'b0, `DTA_ADDR_CONTROL, d);
    check(d, 8'h00, "pin low level");
    pin_to(1'b1);
    $display("Test reset and pin level done");

    // Every mode code written and read back
    for (int m = 0; m < 8; m++) begin
      wr(1'b0, `DTA_ADDR_CONTROL, 8'(m));
      rd(1'b0, `DTA_ADDR_CONTROL, d);
      check(d & 8'h2F, 8'(m), "mode readback");
      check({7'h00, event_pin_oe}, {7'h00, m >= 6}, "pin enable");
      check({7'h00, event_pin_out}, 8'h01, "pin idle high");
    end
    $display("Test mode codes done");

    // Count rate without and with the prescaler, 8 edges apart
    for (int p = 0; p < 2; p++) begin
      wr(1'b0, `DTA_ADDR_CONTROL, p ? 8'h0D : 8'h05);
      wr(1'b0, `DTA_ADDR_SNAPSHOT, 8'hF0);
      wr(1'b0, `DTA_ADDR_SHARED_HIGH, 8'h00);
      rd(1'b0, `DTA_ADDR_COUNT_LOW, e);
      repeat (6) @(negedge clock);
      rd(1'b0, `DTA_ADDR_COUNT_LOW, d);
      check(e - d, p ? 8'(8 / DIV) : 8'h08, "count rate");
    end
    $display("Test prescaler done");

    // Snapshot frozen by the low read across a byte boundary
    wr(1'b0, `DTA_ADDR_CONTROL, 8'h05);
    wr(1'b0, `DTA_ADDR_SNAPSHOT, 8'h04);
    wr(1'b0, `DTA_ADDR_SHARED_HIGH, 8'h01);
    rd(1'b0, `DTA_ADDR_COUNT_LOW, d);
    repeat (20) @(negedge clock);
    rd(1'b0, `DTA_ADDR_SNAPSHOT, d);
    check(d, 8'h01, "snapshot frozen");
    rd(1'b0, `DTA_ADDR_COUNT_LOW, d);
    rd(1'b0, `DTA_ADDR_SHARED_HIGH, d);
    check(d, 8'h00, "snapshot at upper address");
    $display("Test snapshot done");

    // One-shot underflow, reload, flag and per-processor interrupt
    wr(1'b0, `DTA_ADDR_CONTROL, 8'h14);
    wr(1'b0, `DTA_ADDR_SNAPSHOT, 8'h08);
    wr(1'b0, `DTA_ADDR_SHARED_HIGH, 8'h00);
    wait_irq(60);
    repeat (2) @(negedge clock);
    check({6'h00, irq}, 8'h01, "only enabled cpu interrupted");
    rd(1'b0, `DTA_ADDR_COUNT_LOW, d);
    check(d, 8'h08, "reloaded low");
    rd(1'b0, `DTA_ADDR_SNAPSHOT, d);
    check(d, 8'h00, "reloaded high");
    rd(1'b0, `DTA_ADDR_CONTROL, d);
    check(d & 8'h9F, 8'h94, "flag kept by lower read");
    rd(1'b1, `DTA_ADDR_CONTROL, d);
    check(d & 8'h9F, 8'h84, "second cpu view");
    rd(1'b1, `DTA_ADDR_SHARED_HIGH, d);
    repeat (2) @(negedge clock);
    check({6'h00, irq}, 8'h00, "irq after clearing read");
    rd(1'b0, `DTA_ADDR_CONTROL, d);
    check(d & 8'h80, 8'h00, "flag after clearing read");
    $display("Test underflow done");

    // Flag cleared by writing the upper reload byte
    wr(1'b0, `DTA_ADDR_SHARED_HIGH, 8'h00);
    wait_irq(60);
    wr(1'b0, `DTA_ADDR_SNAPSHOT, 8'h40);
    wr(1'b0, `DTA_ADDR_SHARED_HIGH, 8'h00);
    rd(1'b0, `DTA_ADDR_CONTROL, d);
    check(d & 8'h80, 8'h00, "flag after upper write");
    $display("Test write clear done");

    // Event counting on falling pin edges, then held in mode 0
    wr(1'b0, `DTA_ADDR_CONTROL, 8'h01);
    wr(1'b0, `DTA_ADDR_SNAPSHOT, 8'h05);
    wr(1'b0, `DTA_ADDR_SHARED_HIGH, 8'h00);
    repeat (3) begin
      pin_to(1'b0);
      pin_to(1'b1);
    end
    wr(1'b0, `DTA_ADDR_CONTROL, 8'h00);
    rd(1'b0, `DTA_ADDR_COUNT_LOW, d);
    check(d, 8'h02, "three events counted");
    repeat (10) @(negedge clock);
    rd(1'b0, `DTA_ADDR_COUNT_LOW, d);
    check(d, 8'h02, "held while off");
    $display("Test events done");

    // Read-only and unmapped places
    wr(1'b0, `DTA_ADDR_COUNT_LOW, 8'hAA);
    rd(1'b0, `DTA_ADDR_COUNT_LOW, d);
    check(d, 8'h02, "low count not writable");
    rd(1'b0, 8'h20, d);
    check(d, 8'h00, "unmapped read");
    $display("Test access kinds done");

    results();
  end

endmodule // dta_core_bench

`default_nettype wire
